// [src/shp_map.vh]
// Constants for the serial host port I2C master data path
`ifndef SHP_MAP_VH
`define SHP_MAP_VH

// ----------------------------------------------------------------------
// Bus bit levels
// ----------------------------------------------------------------------
`define SHP_ACK 1'b0
`define SHP_NACK 1'b1
`define SHP_DIR_READ 1'b1

// ----------------------------------------------------------------------
// Bit and byte counting
// ----------------------------------------------------------------------
`define SHP_LAST_DATA_BIT 4'h7
`define SHP_ACK_BIT 4'h8
`define SHP_MAX_BYTES 2'h3

// ----------------------------------------------------------------------
// Field positions inside a 24-bit word
// ----------------------------------------------------------------------
`define SHP_WORD_MSB 23
`define SHP_ADDR_DIR_POS 16

// ----------------------------------------------------------------------
// Session modes
// ----------------------------------------------------------------------
`define SHP_MODE_ADDR 2'h0
`define SHP_MODE_RX 2'h1
`define SHP_MODE_TX 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SHP_RST_OE 1'b0
`define SHP_RST_TX_EMPTY 1'b1
`define SHP_RST_IDLE 1'b1

`endif

// [src/shp_i2c_master.v]
// I2C master data path of the serial host port
`timescale 1ns/1ps
`include "shp_map.vh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------

module shp_i2c_master #(
	parameter RATE_W = 8
) (
	input wire clock,
	input wire reset,
	input wire stop_mode,
	input wire port_enable_bit,
	input wire i2c_mode_select,
	input wire master_select,
	input wire [1:0] word_length_select,
	input wire [RATE_W-1:0] clock_rate_register,
	input wire idle_stop_control,
	input wire bus_error_irq_enable,
	input wire bus_error_clear,
	input wire tx_write,
	input wire [23:0] tx_data,
	input wire rx_ready,
	input wire scl_in,
	input wire sda_in,
	output reg [23:0] rx_data,
	output reg rx_fifo_not_empty,
	output reg tx_holding_empty,
	output reg bus_idle,
	output reg bus_error_flag,
	output reg bus_error_irq,
	output reg scl_out,
	output reg scl_oe,
	output reg sda_out,
	output reg sda_oe
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_START = 3'h1;
localparam ST_LOW = 3'h2;
localparam ST_HIGH = 3'h3;
localparam ST_WAIT = 3'h4;
localparam ST_STOP1 = 3'h5;
localparam ST_STOP2 = 3'h6;
localparam ST_STOP3 = 3'h7;

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
// Bytes per word, minus one
function [1:0] shp_last_byte;
	input [1:0] wl;
	begin
		// Codes 0, 1 and 2 give one, two and three bytes; 3 acts as 2
		if (wl == `SHP_MAX_BYTES)
			shp_last_byte = 2'h2;
		else
			shp_last_byte = wl;
	end
endfunction

// Place the first byte to send at the top of the shift register
function [23:0] shp_align;
	input [23:0] word;
	input [1:0] last;
	begin
		case (last)
			2'h0: shp_align = {word[7:0], 16'h0000};
			2'h1: shp_align = {word[15:0], 8'h00};
			default: shp_align = word;
		endcase
	end
endfunction

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
reg scl_s1, scl_s2, scl_s3, scl_f;
reg sda_s1, sda_s2, sda_s3, sda_f;

always @(posedge clock) begin
	scl_s1 <= scl_in;
	scl_s2 <= scl_s1;
	scl_s3 <= scl_s2;
	sda_s1 <= sda_in;
	sda_s2 <= sda_s1;
	sda_s3 <= sda_s2;
	if (reset) begin
		scl_f <= 1'b1;
		sda_f <= 1'b1;
	end else begin
		// A level counts only once two stages agree
		if (scl_s2 == scl_s3)
			scl_f <= scl_s3;
		if (sda_s2 == sda_s3)
			sda_f <= sda_s3;
	end
end

// ----------------------------------------------------------------------
// Engine state
// ----------------------------------------------------------------------
reg [2:0] state;
reg [RATE_W-1:0] timer;
reg [3:0] bit_cnt;
reg [1:0] byte_cnt;
reg [1:0] mode;
reg [23:0] bus_shift_register;
reg [23:0] transmit_holding_register;
reg [23:0] rx_second;
reg rx_second_valid;
reg read_dir;
reg nack;
reg pend_push;

wire ireset = reset | stop_mode | ~port_enable_bit;
wire master_on = i2c_mode_select & master_select;
wire [1:0] last_byte = shp_last_byte(word_length_select);
wire word_end = (byte_cnt == last_byte);
wire tdone = (timer == {RATE_W{1'b0}});
// Control inputs are never stored here, so a port reset keeps them
wire [RATE_W-1:0] half_rate = clock_rate_register >> 1;
wire push = (state == ST_LOW) && pend_push && !rx_second_valid &&
	(mode == `SHP_MODE_RX);
wire pop = rx_fifo_not_empty & rx_ready;
wire load = !tx_holding_empty;

// ----------------------------------------------------------------------
// Receive buffer, two entries
// ----------------------------------------------------------------------
// The head entry is the output register; the second catches a word that
// completes while the reader stalls, so no word is lost.
always @(posedge clock) begin
	if (ireset) begin
		rx_data <= 24'h000000;
		rx_fifo_not_empty <= 1'b0;
		rx_second <= 24'h000000;
		rx_second_valid <= 1'b0;
	end else if (pop) begin
		if (rx_second_valid) begin
			rx_data <= rx_second;
			rx_second_valid <= 1'b0;
		end else begin
			rx_data <= bus_shift_register;
			rx_fifo_not_empty <= push;
		end
	end else if (push) begin
		if (!rx_fifo_not_empty) begin
			rx_data <= bus_shift_register;
			rx_fifo_not_empty <= 1'b1;
		end else begin
			rx_second <= bus_shift_register;
			rx_second_valid <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------------
// Status flags
// ----------------------------------------------------------------------
reg set_error;
reg do_load;

always @(posedge clock) begin
	if (ireset) begin
		bus_error_flag <= 1'b0;
		bus_error_irq <= 1'b0;
	end else begin
		// A new error wins over a clear in the same cycle
		if (set_error)
			bus_error_flag <= 1'b1;
		else if (bus_error_clear)
			bus_error_flag <= 1'b0;
		bus_error_irq <= (bus_error_flag | set_error) &
			bus_error_irq_enable;
	end
end

// ----------------------------------------------------------------------
// Bit engine
// ----------------------------------------------------------------------
always @(posedge clock) begin
	set_error <= 1'b0;
	do_load <= 1'b0;
	scl_out <= 1'b0;
	sda_out <= 1'b0;
	if (ireset) begin
		state <= ST_IDLE;
		timer <= {RATE_W{1'b0}};
		bit_cnt <= 4'h0;
		byte_cnt <= 2'h0;
		mode <= `SHP_MODE_ADDR;
		bus_shift_register <= 24'h000000;
		transmit_holding_register <= 24'h000000;
		tx_holding_empty <= `SHP_RST_TX_EMPTY;
		bus_idle <= `SHP_RST_IDLE;
		read_dir <= 1'b0;
		nack <= 1'b0;
		pend_push <= 1'b0;
		// Pins float in I2C mode or on hard reset, stay as they were otherwise
		if (i2c_mode_select || reset) begin
			scl_oe <= `SHP_RST_OE;
			sda_oe <= `SHP_RST_OE;
		end
	end else begin
		timer <= tdone ? {RATE_W{1'b0}} : timer - 1'b1;
		if (tx_write && tx_holding_empty && !bus_idle) begin
			transmit_holding_register <= tx_data;
			tx_holding_empty <= 1'b0;
		end
		if (push)
			pend_push <= 1'b0;
		case (state)
			ST_IDLE: begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				bus_idle <= 1'b1;
				if (tx_write && master_on) begin
					bus_shift_register <= {tx_data[23:16], 16'h0000};
					read_dir <= tx_data[`SHP_ADDR_DIR_POS];
					mode <= `SHP_MODE_ADDR;
					bit_cnt <= 4'h0;
					byte_cnt <= 2'h0;
					nack <= 1'b0;
					bus_idle <= 1'b0;
					sda_oe <= 1'b1;
					timer <= clock_rate_register;
					state <= ST_START;
				end
			end
			ST_START: begin
				if (tdone) begin
					scl_oe <= 1'b1;
					timer <= clock_rate_register;
					state <= ST_LOW;
				end
			end
			ST_LOW: begin
				scl_oe <= 1'b1;
				// Buffer full: clock held low before the ack bit
				if (pend_push && !push)
					timer <= timer;
				else if (timer == half_rate) begin
					if (bit_cnt == `SHP_ACK_BIT)
						sda_oe <= (mode == `SHP_MODE_RX) &&
							(nack == `SHP_ACK);
					else
						sda_oe <= (mode != `SHP_MODE_RX) &&
							!bus_shift_register[`SHP_WORD_MSB];
				end else if (tdone) begin
					scl_oe <= 1'b0;
					timer <= clock_rate_register;
					state <= ST_HIGH;
				end
			end
			ST_HIGH: begin
				// Slave may stretch the clock; count only once SCL is high
				if (!scl_f)
					timer <= clock_rate_register;
				else if (tdone) begin
					timer <= clock_rate_register;
					scl_oe <= 1'b1;
					state <= ST_LOW;
					if (bit_cnt != `SHP_ACK_BIT) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (mode == `SHP_MODE_RX)
							bus_shift_register <=
								{bus_shift_register[22:0], sda_f};
						else
							bus_shift_register <=
								{bus_shift_register[22:0], 1'b0};
						if (bit_cnt == `SHP_LAST_DATA_BIT &&
							mode == `SHP_MODE_RX) begin
							pend_push <= word_end;
							nack <= idle_stop_control && word_end;
						end
					end else begin
						bit_cnt <= 4'h0;
						byte_cnt <= word_end ? 2'h0 : byte_cnt + 2'h1;
						case (mode)
							`SHP_MODE_ADDR: begin
								byte_cnt <= 2'h0;
								if (sda_f == `SHP_NACK) begin
									set_error <= 1'b1;
									state <= ST_STOP1;
								end else if (read_dir == `SHP_DIR_READ)
									mode <= `SHP_MODE_RX;
								else begin
									mode <= `SHP_MODE_TX;
									if (load) begin
										bus_shift_register <= shp_align(
											transmit_holding_register,
											last_byte);
										tx_holding_empty <= 1'b1;
									end else
										state <= ST_WAIT;
								end
							end
							`SHP_MODE_RX: begin
								sda_oe <= 1'b0;
								if (nack)
									state <= ST_STOP1;
							end
							default: begin
								if (sda_f == `SHP_NACK) begin
									set_error <= 1'b1;
									state <= ST_STOP1;
								end else if (!word_end)
									state <= ST_LOW;
								else if (load) begin
									bus_shift_register <= shp_align(
										transmit_holding_register,
										last_byte);
									tx_holding_empty <= 1'b1;
								end else if (idle_stop_control)
									state <= ST_STOP1;
								else
									state <= ST_WAIT;
							end
						endcase
					end
				end
			end
			ST_WAIT: begin
				// Shift and holding registers both empty
				scl_oe <= 1'b1;
				timer <= clock_rate_register;
				if (load) begin
					bus_shift_register <= shp_align(
						transmit_holding_register, last_byte);
					tx_holding_empty <= 1'b1;
					state <= ST_LOW;
				end else if (idle_stop_control)
					state <= ST_STOP1;
			end
			ST_STOP1: begin
				scl_oe <= 1'b1;
				if (timer == half_rate)
					sda_oe <= 1'b1;
				else if (tdone) begin
					scl_oe <= 1'b0;
					timer <= clock_rate_register;
					state <= ST_STOP2;
				end
			end
			ST_STOP2: begin
				if (!scl_f)
					timer <= clock_rate_register;
				else if (tdone) begin
					sda_oe <= 1'b0;
					timer <= clock_rate_register;
					state <= ST_STOP3;
				end
			end
			default: begin
				if (tdone) begin
					mode <= `SHP_MODE_ADDR;
					pend_push <= 1'b0;
					state <= ST_IDLE;
				end
			end
		endcase
	end
end

endmodule

// [sim/shp_i2c_master_asserts.sv]
// Concurrent checks on the I2C master data path ports
`timescale 1ns/1ps
module shp_i2c_master_asserts (
	input wire clock,
	input wire reset,
	input wire stop_mode,
	input wire port_enable_bit,
	input wire i2c_mode_select,
	input wire master_select,
	input wire bus_error_irq_enable,
	input wire tx_write,
	input wire rx_ready,
	input wire [23:0] rx_data,
	input wire rx_fifo_not_empty,
	input wire tx_holding_empty,
	input wire bus_idle,
	input wire bus_error_flag,
	input wire bus_error_irq,
	input wire scl_oe,
	input wire sda_oe
);
	wire ind_rst = stop_mode | ~port_enable_bit;
	wire run = ~ind_rst & i2c_mode_select & master_select;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ----------
	// Checks
	// ----------
	AST_OE_RST: assert property (ind_rst && i2c_mode_select |=>
		!scl_oe && !sda_oe) else $error("pins driven in reset");
	AST_FLAG_RST: assert property (ind_rst |=> tx_holding_empty &&
		bus_idle && !rx_fifo_not_empty && !bus_error_flag)
		else $error("flags not cleared");
	AST_START: assert property (tx_write && bus_idle && run |=>
		!bus_idle) else $error("no session start");
	AST_NO_MST: assert property (bus_idle && !master_select |=>
		bus_idle) else $error("start without master mode");
	AST_HOLD: assert property (tx_write && !bus_idle &&
		tx_holding_empty && !ind_rst |=> !tx_holding_empty)
		else $error("holding write lost");
	AST_RX_KEEP: assert property (rx_fifo_not_empty && !rx_ready &&
		!ind_rst |=> rx_fifo_not_empty && $stable(rx_data))
		else $error("receive word not held");
	AST_IRQ: assert property (bus_error_irq |->
		$past(bus_error_irq_enable) &&
		(bus_error_flag || $past(bus_error_flag)))
		else $error("irq without cause");
	AST_ERR_STOP: assert property ($rose(bus_error_flag) |->
		##[0:300] bus_idle) else $error("no stop after error");
	cover property (rx_fifo_not_empty && rx_ready);
	cover property ($rose(bus_error_flag));
	cover property (tx_write && bus_idle && run);
endmodule

bind shp_i2c_master shp_i2c_master_asserts u_chk (.clock, .reset,
	.stop_mode, .port_enable_bit, .i2c_mode_select, .master_select,
	.bus_error_irq_enable, .tx_write, .rx_ready, .rx_data,
	.rx_fifo_not_empty, .tx_holding_empty, .bus_idle, .bus_error_flag,
	.bus_error_irq, .scl_oe, .sda_oe);

// [sim/shp_slave_model.sv]
// Behavioural I2C slave on the far side of the bus
`timescale 1ns/1ps
module shp_slave_model #(
	parameter [6:0] ADDR = 7'h50
) (
	input wire scl,
	input wire sda,
	input wire nack_data,
	input wire slow,
	output reg scl_oe,
	output reg sda_oe,
	output reg [15:0] got,
	output reg [7:0] nbytes
);
	reg [7:0] sh;
	reg [7:0] tx;
	reg [3:0] n;
	reg act;
	reg rd;
	reg first;
	initial begin
		{sda_oe, scl_oe, act, rd, first} = 5'h0;
		got = 16'h0;
		nbytes = 8'h0;
		tx = 8'h96;
		n = 4'h0;
	end
	always @(negedge sda) begin
		if (scl) begin
			act = 1'b1;
			first = 1'b1;
			rd = 1'b0;
			n = 4'h0;
		end
	end
	always @(posedge sda) begin
		if (scl) begin
			act = 1'b0;
			sda_oe = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (act) begin
			if (n < 4'h8)
				sh = {sh[6:0], sda};
			else if (rd && !first && sda)
				act = 1'b0;
			n = n + 4'h1;
		end
	end
	// Data changes only while SCL is low; bus released lines read high
	always @(negedge scl) begin
		if (act) begin
			if (n == 4'h8) begin
				if (first) begin
					rd = sh[0];
					sda_oe = (sh[7:1] == ADDR);
				end else if (rd) begin
					sda_oe = 1'b0;
					tx = tx + 8'h11;
				end else begin
					sda_oe = !nack_data;
					got = {got[7:0], sh};
					nbytes = nbytes + 8'h1;
				end
			end else if (n == 4'h9) begin
				n = 4'h0;
				first = 1'b0;
				sda_oe = rd & ~tx[7];
			end else if (rd && !first)
				sda_oe = ~tx[4'h7 - n];
			if (slow) begin
				scl_oe = 1'b1;
				#100;
				scl_oe = 1'b0;
			end
		end
	end
endmodule

// [sim/tb.sv]
// Self-checking bench for the I2C master data path
`timescale 1ns/1ps
module tb;
	reg clock, reset, stop_mode, port_enable_bit, i2c_mode_select;
	reg master_select, idle_stop_control, bus_error_irq_enable;
	reg bus_error_clear, tx_write, rx_ready, slow, nack_data;
	reg [1:0] word_length_select;
	reg [23:0] tx_data;
	wire [23:0] rx_data;
	wire rx_fifo_not_empty, tx_holding_empty, bus_idle, bus_error_flag;
	wire bus_error_irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
	wire [15:0] got;
	wire [7:0] nbytes;
	// Open-drain wires with pull-ups
	wire scl = ~(scl_oe | s_scl_oe);
	wire sda = ~(sda_oe | s_sda_oe);
	integer err_count, checks, cyc, k;

	shp_i2c_master #(.RATE_W(8)) dut (.clock, .reset, .stop_mode,
		.port_enable_bit, .i2c_mode_select, .master_select,
		.word_length_select, .clock_rate_register(8'h04),
		.idle_stop_control, .bus_error_irq_enable, .bus_error_clear,
		.tx_write, .tx_data, .rx_ready, .scl_in(scl), .sda_in(sda),
		.rx_data, .rx_fifo_not_empty, .tx_holding_empty, .bus_idle,
		.bus_error_flag, .bus_error_irq, .scl_out(), .scl_oe,
		.sda_out(), .sda_oe);
	shp_slave_model #(.ADDR(7'h50)) slv (.scl, .sda, .nack_data, .slow,
		.scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .got, .nbytes);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			err_count = err_count + 1;
			summarize;
		end
	end
	// ----------
	// Helpers
	// ----------
	task check(input [23:0] seen, input [23:0] exp, input [63:0] name);
	begin
		checks = checks + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("wrong value %0s: expected %h, seen %h", name, exp, seen);
		end
	end
	endtask
	task summarize;
	begin
		$display("checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task tick(input integer n);
	begin
		repeat (n) @(posedge clock);
		#1;
	end
	endtask
	task put(input [23:0] d);
	begin
		tx_write = 1'b1;
		tx_data = d;
		tick(1);
		tx_write = 1'b0;
		tick(1);
	end
	endtask
	// Hangs here are cut short by the cycle ceiling
	task idle;
	begin
		while (bus_idle !== 1'b1)
			tick(1);
	end
	endtask
	task hold_empty;
	begin
		while (tx_holding_empty !== 1'b1)
			tick(1);
	end
	endtask
	task clr;
	begin
		bus_error_clear = 1'b1;
		tick(1);
		bus_error_clear = 1'b0;
		tick(1);
		check(bus_error_flag, 0, "clear");
	end
	endtask
	function [7:0] bt(input integer b);
		bt = 8'h96 + b[7:0] * 8'h11;
	endfunction
	// ----------
	// Scenarios
	// ----------
	task t_tx;
	begin
		word_length_select = 2'h1;
		slow = 1'b1;
		put(24'ha00000);
		check(bus_idle, 0, "busy");
		hold_empty;
		put(24'h003c5a);
		check(tx_holding_empty, 0, "hold");
		hold_empty;
		while (nbytes !== 8'h02)
			tick(1);
		check(got, 16'h3c5a, "txword");
		tick(200);
		check({bus_idle, scl}, 0, "stall");
		idle_stop_control = 1'b1;
		idle;
		check(nbytes, 2, "ntx");
		idle_stop_control = 1'b0;
		slow = 1'b0;
	end
	endtask
	task t_txnack;
	begin
		nack_data = 1'b1;
		k = nbytes;
		put(24'ha00000);
		hold_empty;
		put(24'h00c377);
		idle;
		check(nbytes, k + 1, "ntx");
		check(bus_error_flag, 1, "error");
		nack_data = 1'b0;
		clr;
	end
	endtask
	task t_addr;
	begin
		bus_error_irq_enable = 1'b1;
		put(24'h420000);
		idle;
		tick(2);
		check({bus_error_flag, bus_error_irq}, 3, "irq");
		clr;
		bus_error_irq_enable = 1'b0;
	end
	endtask
	task t_rx;
	begin
		word_length_select = 2'h2;
		put(24'ha10000);
		tick(3000);
		check({rx_fifo_not_empty, bus_idle, scl}, 4, "stretch");
		rx_ready = 1'b1;
		idle_stop_control = 1'b1;
		k = 0;
		while (bus_idle !== 1'b1 || rx_fifo_not_empty !== 1'b0) begin
			if (rx_fifo_not_empty === 1'b1) begin
				check(rx_data, {bt(3*k), bt(3*k+1), bt(3*k+2)}, "rxword");
				k = k + 1;
			end
			tick(1);
		end
		check(k, 4, "words");
		rx_ready = 1'b0;
		idle_stop_control = 1'b0;
	end
	endtask
	task t_stop;
	begin
		master_select = 1'b0;
		put(24'ha00000);
		tick(2);
		check(bus_idle, 1, "nomaster");
		master_select = 1'b1;
		put(24'ha00000);
		tick(30);
		stop_mode = 1'b1;
		tick(2);
		check({bus_idle, tx_holding_empty, scl_oe, sda_oe}, 12, "stop");
		put(24'ha00000);
		tick(2);
		check(bus_idle, 1, "stop");
		port_enable_bit = 1'b0;
		stop_mode = 1'b0;
		tick(2);
		check({bus_idle, scl_oe, sda_oe}, 4, "disable");
		port_enable_bit = 1'b1;
		tick(2);
	end
	endtask
	initial begin
		{stop_mode, idle_stop_control, bus_error_irq_enable, bus_error_clear,
			tx_write, rx_ready, slow, nack_data, word_length_select} = 0;
		{reset, port_enable_bit, i2c_mode_select, master_select} = 4'hf;
		tx_data = 24'h0;
		err_count = 0;
		checks = 0;
		cyc = 0;
		tick(8);
		reset = 1'b0;
		tick(1);
		check({tx_holding_empty, bus_idle, rx_fifo_not_empty, bus_error_flag,
			scl_oe, sda_oe}, 6'h30, "reset");
		t_tx;
		t_txnack;
		t_addr;
		t_rx;
		t_stop;
		summarize;
	end
endmodule
